/* File: hw/pdf_params.svh */
// Purpose: numeric constants of the program download framer
// Assumes: 250 MHz system clock
// Notes:   all offsets, codes, lengths and timing counts live here
`ifndef PDF_PARAMS_SVH
`define PDF_PARAMS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define PDF_STX          8'h02
`define PDF_FT_HI        8'h01
`define PDF_FT_LO        8'h00
`define PDF_HDR_LEN      8'h07
`define PDF_SEG_HDR      8'h09

// ----------------------------------------------------------------
// command codes and payload lengths
// ----------------------------------------------------------------
`define PDF_CN_DL_REQ    8'h00
`define PDF_CN_DL_RSP    8'h80
`define PDF_CN_DONE_NTF  8'h01
`define PDF_CN_DONE_RSP  8'h81
`define PDF_LEN_DL_REQ   16'h0012
`define PDF_LEN_INFO_RSP 16'h000E
`define PDF_LEN_DONE_NTF 16'h0001
`define PDF_LEN_DONE_RSP 16'h0000
`define PDF_LEN_SEG_NUM  16'h0002
`define PDF_SEG_MAX      128
`define PDF_LEN_RX_MAX   16'h0082

// ----------------------------------------------------------------
// field values
// ----------------------------------------------------------------
`define PDF_FN_NONE      8'h00
`define PDF_FN_FIRST     8'h01
`define PDF_FN_LAST      8'hFF
`define PDF_RESULT_FAIL  8'h00
`define PDF_RESULT_OK    8'h01
`define PDF_TYPE_PROG    8'h00
`define PDF_TYPE_SRC     8'h01
`define PDF_FILL         8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PDF_T1_MS        300
`define PDF_CLK_KHZ      250000
`define PDF_T1_CYC       (`PDF_T1_MS * `PDF_CLK_KHZ)
`define PDF_RETRY_MAX    3

`endif

/* File: hw/pdf_pkg.sv */
// Purpose: shared types and helpers of the program download framer
// Assumes: pdf_params.svh holds the numbers
// Notes:   both link ends import this package
`include "pdf_params.svh"
`default_nettype none

package pdf_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [7:0] pdf_byte_t;

  // receive parser position within a frame
  typedef enum logic [3:0] {
    RX_STX, RX_FT_HI, RX_FT_LO, RX_CN, RX_FN, RX_LEN_HI, RX_LEN_LO, RX_PAY, RX_FCC
  } pdf_rx_state_t;

  // which answer the equipment end builds
  typedef enum logic [1:0] {RSP_INFO, RSP_SEG, RSP_ACK} pdf_rsp_kind_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // frame number wraps from the last value back to the first, never 0
  function automatic pdf_byte_t pdf_next_fn(input pdf_byte_t fn);
    return (fn == `PDF_FN_LAST) ? `PDF_FN_FIRST : 8'(fn + 8'h01);
  endfunction : pdf_next_fn

  // fixed seven header bytes, index 0 is the start byte
  function automatic pdf_byte_t pdf_hdr_byte(input pdf_byte_t   idx,
                                             input pdf_byte_t   cn,
                                             input pdf_byte_t   fn,
                                             input logic [15:0] len);
    case (idx)
      8'h00:   return `PDF_STX;
      8'h01:   return `PDF_FT_HI;
      8'h02:   return `PDF_FT_LO;
      8'h03:   return cn;
      8'h04:   return fn;
      8'h05:   return len[15:8];
      8'h06:   return len[7:0];
      default: return 8'h00;
    endcase
  endfunction : pdf_hdr_byte

endpackage : pdf_pkg

`default_nettype wire

/* File: hw/pdf_link_if.sv */
// Purpose: byte stream link between adapter and equipment ends
// Assumes: one byte per cycle while valid is high, no back-pressure
// Notes:   frames are delimited by their own length field
`default_nettype none

interface pdf_link_if (
  // clock
  input wire logic clk_sys
);
  logic             a2e_valid;
  pdf_pkg::pdf_byte_t a2e_data;
  logic             e2a_valid;
  pdf_pkg::pdf_byte_t e2a_data;

  // adapter sends requests and notifications
  modport adapter (output a2e_valid, output a2e_data, input e2a_valid, input e2a_data);
  // equipment sends responses
  modport equipment (input a2e_valid, input a2e_data, output e2a_valid, output e2a_data);
endinterface : pdf_link_if

`default_nettype wire

/* File: hw/pdf_equipment.sv */
// Purpose: equipment end, parses requests and builds responses
// Assumes: user answers each request through rsp_start
// Notes:   segment data is staged in a local memory before sending
`include "pdf_params.svh"
`default_nettype none

module pdf_equipment #(
  parameter bit ECHO_FN = 1'b1
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // link
  pdf_link_if.equipment                link,
  // decoded requests
  output var  logic                    req_valid,
  output var  logic [15:0]             req_seq,
  output var  logic [55:0]             req_target,
  output var  logic [71:0]             req_sw,
  output var  logic                    note_valid,
  output var  logic                    note_ok,
  output var  logic                    rx_err,
  // segment data staging
  input  wire logic                    wr_en,
  input  wire logic [6:0]              wr_addr,
  input  wire pdf_pkg::pdf_byte_t      wr_data,
  // answer
  input  wire logic                    rsp_start,
  input  wire pdf_pkg::pdf_rsp_kind_t  rsp_kind,
  input  wire pdf_pkg::pdf_byte_t      info_type,
  input  wire logic [15:0]             info_count,
  input  wire logic [71:0]             info_sw,
  input  wire logic [15:0]             info_size,
  input  wire logic [15:0]             seg_num,
  input  wire pdf_pkg::pdf_byte_t      seg_len,
  output var  logic                    rsp_busy
);
  import pdf_pkg::*;

  pdf_rx_state_t rx_st_r;
  pdf_byte_t     rx_sum_r, rx_cn_r, rx_fn_r, req_fn_r;
  logic [15:0]   rx_len_r, rx_cnt_r;
  logic          rx_bad_r;
  logic [143:0]  rx_pay_r;
  pdf_byte_t     seg_mem [0:`PDF_SEG_MAX-1];
  pdf_rsp_kind_t kind_r;
  pdf_byte_t     cn_r, fn_r, idx_r, sum_r, tx_byte, seg_len_c;
  logic [15:0]   len_r;
  logic [111:0]  sh_r;
  logic          on_r, e2a_valid_r;
  pdf_byte_t     e2a_data_r;
  pdf_byte_t     b;

  assign b             = link.a2e_data;
  assign link.e2a_valid = e2a_valid_r;
  assign link.e2a_data  = e2a_data_r;
  assign rsp_busy      = on_r;
  assign seg_len_c     = (seg_len > 8'(`PDF_SEG_MAX)) ? 8'(`PDF_SEG_MAX) : seg_len;

  // ----------------------------------------------------------------
  // request parser
  // ----------------------------------------------------------------
  // hunts for the start byte, so stray bytes between frames are dropped
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_st_r <= RX_STX;
      rx_sum_r <= 8'h00;
      rx_cn_r <= 8'h00;
      rx_fn_r <= 8'h00;
      rx_len_r <= 16'h0000;
      rx_cnt_r <= 16'h0000;
      rx_bad_r <= 1'b0;
      rx_pay_r <= '0;
      req_fn_r <= 8'h00;
      req_valid <= 1'b0;
      req_seq <= 16'h0000;
      req_target <= '0;
      req_sw <= '0;
      note_valid <= 1'b0;
      note_ok <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      req_valid <= 1'b0;
      note_valid <= 1'b0;
      rx_err <= 1'b0;
      if (link.a2e_valid) begin
        case (rx_st_r)
          RX_STX: if (b == `PDF_STX) rx_st_r <= RX_FT_HI;
          RX_FT_HI: begin
            rx_sum_r <= b;
            rx_bad_r <= (b != `PDF_FT_HI);
            rx_st_r <= RX_FT_LO;
          end
          RX_FT_LO: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rx_bad_r <= rx_bad_r | (b != `PDF_FT_LO);
            rx_st_r <= RX_CN;
          end
          RX_CN: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rx_cn_r <= b;
            rx_st_r <= RX_FN;
          end
          RX_FN: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rx_fn_r <= b;
            rx_st_r <= RX_LEN_HI;
          end
          RX_LEN_HI: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rx_len_r[15:8] <= b;
            rx_st_r <= RX_LEN_LO;
          end
          RX_LEN_LO: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rx_len_r[7:0] <= b;
            rx_cnt_r <= 16'h0000;
            rx_st_r <= ({rx_len_r[15:8], b} == 16'h0000) ? RX_FCC : RX_PAY;
          end
          RX_PAY: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rx_pay_r <= {rx_pay_r[135:0], b};
            rx_cnt_r <= 16'(rx_cnt_r + 16'h0001);
            if (rx_cnt_r == 16'(rx_len_r - 16'h0001)) rx_st_r <= RX_FCC;
          end
          RX_FCC: begin
            rx_st_r <= RX_STX;
            if (rx_bad_r || (8'(rx_sum_r + b) != 8'h00)) begin
              rx_err <= 1'b1;
            end else if (rx_cn_r == `PDF_CN_DL_REQ && rx_len_r == `PDF_LEN_DL_REQ) begin
              req_valid <= 1'b1;
              req_seq <= rx_pay_r[143:128];
              req_target <= rx_pay_r[127:72];
              req_sw <= rx_pay_r[71:0];
              req_fn_r <= rx_fn_r;
            end else if (rx_cn_r == `PDF_CN_DONE_NTF && rx_len_r == `PDF_LEN_DONE_NTF) begin
              note_valid <= 1'b1;
              note_ok <= (rx_pay_r[7:0] == `PDF_RESULT_OK);
              req_fn_r <= rx_fn_r;
            end else begin
              rx_err <= 1'b1;
            end
          end
          default: rx_st_r <= RX_STX;
        endcase
      end
    end
  end

  // segment data memory, written by the user before answering
  always_ff @(posedge clk_sys) begin
    if (wr_en) seg_mem[wr_addr] <= wr_data;
  end

  // ----------------------------------------------------------------
  // response builder
  // ----------------------------------------------------------------
  always_comb begin
    if (idx_r < `PDF_HDR_LEN) begin
      tx_byte = pdf_hdr_byte(idx_r, cn_r, fn_r, len_r);
    end else if (idx_r == 8'(`PDF_HDR_LEN + len_r[7:0])) begin
      tx_byte = 8'(8'h00 - sum_r);
    end else if (kind_r == RSP_SEG && idx_r >= `PDF_SEG_HDR) begin
      tx_byte = seg_mem[7'(idx_r - `PDF_SEG_HDR)];
    end else begin
      tx_byte = sh_r[111:104];
    end
  end

  // a start while a response is still going out is ignored
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      on_r <= 1'b0;
      kind_r <= RSP_ACK;
      cn_r <= `PDF_CN_DONE_RSP;
      fn_r <= `PDF_FN_NONE;
      len_r <= 16'h0000;
      sh_r <= '0;
      idx_r <= 8'h00;
      sum_r <= 8'h00;
      e2a_valid_r <= 1'b0;
      e2a_data_r <= 8'h00;
    end else begin
      e2a_valid_r <= on_r;
      e2a_data_r <= tx_byte;
      if (rsp_start && !on_r) begin
        on_r <= 1'b1;
        kind_r <= rsp_kind;
        idx_r <= 8'h00;
        sum_r <= 8'h00;
        fn_r <= ECHO_FN ? req_fn_r : `PDF_FN_NONE;
        case (rsp_kind)
          RSP_INFO: begin
            cn_r <= `PDF_CN_DL_RSP;
            len_r <= `PDF_LEN_INFO_RSP;
            sh_r <= {info_type, info_count,
                     (info_type == `PDF_TYPE_SRC) ? {9{`PDF_FILL}} : info_sw,
                     info_size};
          end
          RSP_SEG: begin
            cn_r <= `PDF_CN_DL_RSP;
            len_r <= 16'(`PDF_LEN_SEG_NUM + {8'h00, seg_len_c});
            sh_r <= {seg_num, 96'h0};
          end
          default: begin
            cn_r <= `PDF_CN_DONE_RSP;
            len_r <= `PDF_LEN_DONE_RSP;
            sh_r <= '0;
          end
        endcase
      end else if (on_r) begin
        idx_r <= 8'(idx_r + 8'h01);
        if (idx_r != 8'h00) sum_r <= 8'(sum_r + tx_byte);
        if (idx_r >= `PDF_HDR_LEN) sh_r <= {sh_r[103:0], 8'h00};
        if (idx_r == 8'(`PDF_HDR_LEN + len_r[7:0])) on_r <= 1'b0;
      end
    end
  end

endmodule : pdf_equipment

`default_nettype wire

/* File: hw/pdf_adapter.sv */
// Purpose: adapter end, issues download requests and completion notes
// Assumes: target and software info come from an earlier recognition step
// Notes:   one outstanding request at a time, with timed retransmission
`include "pdf_params.svh"
`default_nettype none

module pdf_adapter #(
  parameter int unsigned T1_CYC    = `PDF_T1_CYC,
  parameter int unsigned RETRY_MAX = `PDF_RETRY_MAX
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // link
  pdf_link_if.adapter              link,
  // download request
  input  wire logic                dl_start,
  input  wire logic [15:0]         dl_seq,
  input  wire logic [55:0]         target_info,
  input  wire logic                sw_held,
  input  wire logic [71:0]         sw_info,
  // completion notification
  input  wire logic                done_start,
  input  wire logic                done_ok,
  // exchange status
  output var  logic                busy,
  output var  logic                rsp_valid,
  output var  pdf_pkg::pdf_byte_t  rsp_cmd,
  output var  pdf_pkg::pdf_byte_t  rsp_fn,
  output var  logic [15:0]         rsp_len,
  output var  logic                dl_error,
  output var  logic                frame_err,
  // received payload bytes
  output var  logic                pay_valid,
  output var  pdf_pkg::pdf_byte_t  pay_data,
  output var  pdf_pkg::pdf_byte_t  pay_index
);
  import pdf_pkg::*;

  typedef enum logic [1:0] {A_IDLE, A_SEND, A_WAIT} pdf_ctl_state_t;

  pdf_ctl_state_t st_r;
  pdf_byte_t      fn_r, cn_r, exp_cn;
  logic [15:0]    len_r;
  logic [143:0]   hold_r, sh_r;
  logic [3:0]     retry_r;
  logic [31:0]    tmo_r;
  logic           tx_go_r, tx_on_r, tx_done_r;
  pdf_byte_t      idx_r, sum_r, tx_byte;
  logic           a2e_valid_r;
  pdf_byte_t      a2e_data_r;
  pdf_rx_state_t  rx_st_r;
  pdf_byte_t      rx_sum_r;
  logic [15:0]    rx_cnt_r;
  logic           rx_bad_r, rx_end_r, rx_ok_r;
  logic           rsp_good, rsp_fail;
  pdf_byte_t      b;

  assign b              = link.e2a_data;
  assign link.a2e_valid = a2e_valid_r;
  assign link.a2e_data  = a2e_data_r;

  // ----------------------------------------------------------------
  // response acceptance
  // ----------------------------------------------------------------
  // frame number zero is accepted from equipment that cannot echo
  assign exp_cn   = (cn_r == `PDF_CN_DL_REQ) ? `PDF_CN_DL_RSP : `PDF_CN_DONE_RSP;
  assign rsp_good = rx_end_r && rx_ok_r && rsp_cmd == exp_cn
                    && (rsp_fn == `PDF_FN_NONE || rsp_fn == fn_r);
  assign rsp_fail = rx_end_r || (tmo_r >= T1_CYC - 1);

  // ----------------------------------------------------------------
  // exchange control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_r <= A_IDLE;
      fn_r <= `PDF_FN_NONE;
      cn_r <= `PDF_CN_DL_REQ;
      len_r <= 16'h0000;
      hold_r <= '0;
      retry_r <= 4'h0;
      tmo_r <= 32'h0000_0000;
      tx_go_r <= 1'b0;
      busy <= 1'b0;
      rsp_valid <= 1'b0;
      dl_error <= 1'b0;
    end else begin
      tx_go_r <= 1'b0;
      rsp_valid <= 1'b0;
      dl_error <= 1'b0;
      case (st_r)
        A_IDLE: begin
          if (dl_start || done_start) begin
            fn_r <= pdf_next_fn(fn_r);
            retry_r <= 4'h0;
            tx_go_r <= 1'b1;
            busy <= 1'b1;
            st_r <= A_SEND;
            if (dl_start) begin
              cn_r <= `PDF_CN_DL_REQ;
              len_r <= `PDF_LEN_DL_REQ;
              hold_r <= {dl_seq, target_info,
                         sw_held ? sw_info : {9{`PDF_FILL}}};
            end else begin
              cn_r <= `PDF_CN_DONE_NTF;
              len_r <= `PDF_LEN_DONE_NTF;
              hold_r <= {done_ok ? `PDF_RESULT_OK : `PDF_RESULT_FAIL, 136'h0};
            end
          end
        end
        A_SEND: begin
          tmo_r <= 32'h0000_0000;
          if (tx_done_r) st_r <= A_WAIT;
        end
        A_WAIT: begin
          tmo_r <= 32'(tmo_r + 32'h0000_0001);
          if (rsp_good) begin
            rsp_valid <= 1'b1;
            busy <= 1'b0;
            st_r <= A_IDLE;
          end else if (rsp_fail) begin
            // same frame number on a retransmission, so a late echo still matches
            if (retry_r == 4'(RETRY_MAX)) begin
              dl_error <= 1'b1;
              busy <= 1'b0;
              st_r <= A_IDLE;
            end else begin
              retry_r <= 4'(retry_r + 4'h1);
              tx_go_r <= 1'b1;
              st_r <= A_SEND;
            end
          end
        end
        default: st_r <= A_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame serializer
  // ----------------------------------------------------------------
  always_comb begin
    if (idx_r < `PDF_HDR_LEN) begin
      tx_byte = pdf_hdr_byte(idx_r, cn_r, fn_r, len_r);
    end else if (idx_r == 8'(`PDF_HDR_LEN + len_r[7:0])) begin
      tx_byte = 8'(8'h00 - sum_r);
    end else begin
      tx_byte = sh_r[143:136];
    end
  end

  // payload kept in hold_r so a retransmission rebuilds the same frame
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_on_r <= 1'b0;
      tx_done_r <= 1'b0;
      idx_r <= 8'h00;
      sum_r <= 8'h00;
      sh_r <= '0;
      a2e_valid_r <= 1'b0;
      a2e_data_r <= 8'h00;
    end else begin
      tx_done_r <= 1'b0;
      a2e_valid_r <= tx_on_r;
      a2e_data_r <= tx_byte;
      if (tx_go_r) begin
        tx_on_r <= 1'b1;
        idx_r <= 8'h00;
        sum_r <= 8'h00;
        sh_r <= hold_r;
      end else if (tx_on_r) begin
        idx_r <= 8'(idx_r + 8'h01);
        if (idx_r != 8'h00) sum_r <= 8'(sum_r + tx_byte);
        if (idx_r >= `PDF_HDR_LEN) sh_r <= {sh_r[135:0], 8'h00};
        if (idx_r == 8'(`PDF_HDR_LEN + len_r[7:0])) begin
          tx_on_r <= 1'b0;
          tx_done_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // response parser
  // ----------------------------------------------------------------
  // payload bytes stream out at once; only rsp_valid commits them,
  // a trade against holding a 130 byte copy here
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_st_r <= RX_STX;
      rx_sum_r <= 8'h00;
      rx_cnt_r <= 16'h0000;
      rx_bad_r <= 1'b0;
      rx_end_r <= 1'b0;
      rx_ok_r <= 1'b0;
      rsp_cmd <= 8'h00;
      rsp_fn <= 8'h00;
      rsp_len <= 16'h0000;
      frame_err <= 1'b0;
      pay_valid <= 1'b0;
      pay_data <= 8'h00;
      pay_index <= 8'h00;
    end else begin
      rx_end_r <= 1'b0;
      frame_err <= 1'b0;
      pay_valid <= 1'b0;
      if (link.e2a_valid) begin
        case (rx_st_r)
          RX_STX: if (b == `PDF_STX) rx_st_r <= RX_FT_HI;
          RX_FT_HI: begin
            rx_sum_r <= b;
            rx_bad_r <= (b != `PDF_FT_HI);
            rx_st_r <= RX_FT_LO;
          end
          RX_FT_LO: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rx_bad_r <= rx_bad_r | (b != `PDF_FT_LO);
            rx_st_r <= RX_CN;
          end
          RX_CN: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rsp_cmd <= b;
            rx_st_r <= RX_FN;
          end
          RX_FN: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rsp_fn <= b;
            rx_st_r <= RX_LEN_HI;
          end
          RX_LEN_HI: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rsp_len[15:8] <= b;
            rx_st_r <= RX_LEN_LO;
          end
          RX_LEN_LO: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            rsp_len[7:0] <= b;
            rx_cnt_r <= 16'h0000;
            // oversize answers are marked bad: beyond what a segment may hold
            rx_bad_r <= rx_bad_r | ({rsp_len[15:8], b} > `PDF_LEN_RX_MAX);
            rx_st_r <= ({rsp_len[15:8], b} == 16'h0000) ? RX_FCC : RX_PAY;
          end
          RX_PAY: begin
            rx_sum_r <= 8'(rx_sum_r + b);
            pay_valid <= 1'b1;
            pay_data <= b;
            pay_index <= rx_cnt_r[7:0];
            rx_cnt_r <= 16'(rx_cnt_r + 16'h0001);
            if (rx_cnt_r == 16'(rsp_len - 16'h0001)) rx_st_r <= RX_FCC;
          end
          RX_FCC: begin
            rx_st_r <= RX_STX;
            rx_end_r <= 1'b1;
            rx_ok_r <= !rx_bad_r && (8'(rx_sum_r + b) == 8'h00);
            frame_err <= rx_bad_r || (8'(rx_sum_r + b) != 8'h00);
          end
          default: rx_st_r <= RX_STX;
        endcase
      end
    end
  end

endmodule : pdf_adapter

`default_nettype wire

/* File: testbench/pdf_link_assertions.sv */
// Purpose: wire checks on the download link
// Assumes: one clock, sync active-low reset
// Notes:   sits beside the link in tb_top
`default_nettype none
module pdf_link_assertions (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rstn,
  // both directions
  input wire logic               a2e_valid,
  input wire pdf_pkg::pdf_byte_t a2e_data,
  input wire logic               e2a_valid,
  input wire pdf_pkg::pdf_byte_t e2a_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import pdf_pkg::*;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // frame type pair right after the start byte
  sequence ft_a; ##1 a2e_data == 8'h01 ##1 a2e_data == 8'h00; endsequence
  sequence ft_e; ##1 e2a_data == 8'h01 ##1 e2a_data == 8'h00; endsequence
  a_stx_adp: assert property ($rose(a2e_valid) |-> a2e_data == 8'h02)
    else $error("a2e start byte");
  a_ft_adp: assert property ($rose(a2e_valid) |-> ft_a)
    else $error("a2e frame type");
  a_cn_adp: assert property ($rose(a2e_valid) |-> ##3 a2e_data inside {8'h00, 8'h01})
    else $error("a2e command code");
  a_fn_adp: assert property ($rose(a2e_valid) |-> ##4 a2e_data != 8'h00)
    else $error("a2e frame number zero");
  a_len_adp: assert property ($rose(a2e_valid) |->
    ##5 a2e_data == 8'h00 ##1 a2e_data inside {8'h12, 8'h01})
    else $error("a2e length");
  // shortest frame has eight bytes back to back
  a_run_adp: assert property ($rose(a2e_valid) |-> a2e_valid [*8])
    else $error("a2e frame gap");
  a_stx_eqp: assert property ($rose(e2a_valid) |-> e2a_data == 8'h02)
    else $error("e2a start byte");
  a_ft_eqp: assert property ($rose(e2a_valid) |-> ft_e)
    else $error("e2a frame type");
  a_cn_eqp: assert property ($rose(e2a_valid) |-> ##3 e2a_data inside {8'h80, 8'h81})
    else $error("e2a command code");
endmodule : pdf_link_assertions
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: adapter and equipment ends joined back to back
// Assumes: short response timeout so retries end fast
// Notes:   pulses land in sticky flags cleared per exchange
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pdf_pkg::*;
  logic clk_sys, rstn, dl_start, sw_held, done_start, done_ok, wr_en, rsp_start, busy;
  logic rsp_valid, dl_error, req_valid, note_valid, note_ok, rsp_busy, g_req, g_rsp, g_err;
  logic clr, g_bad, frame_err, rx_err, pay_valid;
  logic [6:0] wr_addr;
  logic [15:0] dl_seq, rsp_len, req_seq, seg_num, info_count, info_size, pq;
  logic [55:0] target_info, req_target;
  logic [71:0] sw_info, req_sw, info_sw;
  pdf_byte_t rsp_cmd, rsp_fn, wr_data, info_type, seg_len, pay_data, pay_index, qa[$], qe[$];
  pdf_rsp_kind_t rsp_kind;
  int err_count, n_tests;
  pdf_link_if link (.clk_sys);
  pdf_adapter #(.T1_CYC(200)) pdf_adapter_inst (.clk_sys, .rstn, .link(link.adapter),
    .dl_start, .dl_seq, .target_info, .sw_held, .sw_info, .done_start, .done_ok, .busy,
    .rsp_valid, .rsp_cmd, .rsp_fn, .rsp_len, .dl_error, .frame_err, .pay_valid,
    .pay_data, .pay_index);
  pdf_equipment pdf_equipment_inst (.clk_sys, .rstn, .link(link.equipment), .req_valid,
    .req_seq, .req_target, .req_sw, .note_valid, .note_ok, .rx_err, .wr_en, .wr_addr,
    .wr_data, .rsp_start, .rsp_kind, .info_type, .info_count, .info_sw, .info_size,
    .seg_num, .seg_len, .rsp_busy);
  pdf_link_assertions pdf_link_assertions_inst (.clk_sys, .rstn,
    .a2e_valid(link.a2e_valid), .a2e_data(link.a2e_data),
    .e2a_valid(link.e2a_valid), .e2a_data(link.e2a_data));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // capture link bytes and sticky pulses; only this process writes them
  always @(posedge clk_sys) begin
    if (clr) begin
      qa.delete();
      qe.delete();
      {g_req, g_rsp, g_err, g_bad} <= 4'h0;
    end else begin
      if (link.a2e_valid) qa.push_back(link.a2e_data);
      if (link.e2a_valid) qe.push_back(link.e2a_data);
      if (req_valid || note_valid) g_req <= 1'b1;
      if (rsp_valid) g_rsp <= 1'b1;
      if (dl_error) g_err <= 1'b1;
      if (frame_err || rx_err) g_bad <= 1'b1;
      if (pay_valid) pq <= {pay_index, pay_data};
    end
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [143:0] got, input logic [143:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  // size, command and checksum of one captured frame
  task automatic fr(input string nm, input pdf_byte_t q[$], input pdf_byte_t cn,
                    input logic [15:0] ln);
    pdf_byte_t s;
    s = 8'h00;
    foreach (q[i]) if (i > 0) s += q[i];
    chk(nm, {q.size(), q[3], s}, {32'(ln) + 32'h8, cn, 8'h00});
  endtask : fr
  // one exchange; the equipment answers only when ans is set
  task automatic ex(input logic dn, input logic [15:0] sq, input logic ans,
                    input pdf_rsp_kind_t k);
    int i;
    clr = 1'b1;
    {dl_seq, done_start, dl_start} = {sq, dn, !dn};
    tick();
    {clr, done_start, dl_start} = 3'h0;
    for (i = 0; i < 99 && ans && !g_req; i++) tick();
    if (ans) chk("seen", g_req, 1'b1);
    {rsp_kind, rsp_start} = {k, ans};
    tick();
    rsp_start = 1'b0;
    for (i = 0; i < 3000 && busy; i++) tick();
    // one more edge so the end pulses reach the sticky flags
    tick();
    chk("idle", busy, 1'b0);
  endtask : ex
  task automatic close_out();
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  initial begin
    {clr, rstn, dl_start, done_start, done_ok, sw_held, wr_en, rsp_start, dl_seq} = '0;
    {wr_addr, wr_data, rsp_kind, seg_num, seg_len} = {7'h0, 8'h0, RSP_ACK, 16'h0102, 8'h03};
    {info_type, info_count, info_sw, info_size} = {8'h01, 16'h0004, 72'h0, 16'h0200};
    {target_info, sw_info} = {56'h11223344556677, 72'hABCDEF010203040506};
    repeat (12) tick();
    rstn = 1'b1;
    tick();
    ex(1'b0, 16'h0000, 1'b1, RSP_INFO);
    chk("req0", {req_seq, req_target, req_sw}, {16'h0, target_info, {9{8'hFF}}});
    fr("req0", qa, 8'h00, 16'h0012);
    chk("rsp0", {g_rsp, rsp_cmd, rsp_fn, rsp_len, qa[4]}, 41'h1_8001_000E_01);
    chk("info_sw", {qe[10], qe[18]}, 16'hFFFF);
    for (int i = 0; i < 3; i++) begin
      {wr_en, wr_addr, wr_data} = {1'b1, 7'(i), 8'hA0 + 8'(i)};
      tick();
    end
    {wr_en, sw_held} = 2'h1;
    ex(1'b0, 16'h0102, 1'b1, RSP_SEG);
    chk("req1", {req_sw, req_seq, qa[4]}, {sw_info, 16'h0102, 8'h02});
    fr("seg", qe, 8'h80, 16'h0005);
    chk("seg_pay", {qe[7], qe[8], qe[9], qe[11]}, 32'h0102A0A2);
    chk("pay", {g_bad, rsp_busy, pq}, 18'h004A2);
    done_ok = 1'b1;
    ex(1'b1, 16'h0000, 1'b1, RSP_ACK);
    fr("note", qa, 8'h01, 16'h0001);
    fr("ack", qe, 8'h81, 16'h0000);
    chk("note", {note_ok, qa[7], rsp_cmd, rsp_fn}, 25'h1_01_8103);
    ex(1'b0, 16'h0001, 1'b0, RSP_ACK);
    chk("retry", {g_bad, g_err, 8'(qa.size()), qa[82]}, 18'h16804);
    close_out();
  end
  // hang guard well past the longest expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
